// *** hw/slpg_top.sv ***
// How it works
// - six software-selected sleep modes: idle, adc noise, save, down, standby, ext standby
// - idle stops the core clock; memory, timers, serial port, interrupts keep running
// - power-down stops oscillator and all functions, keeps state, until interrupt or reset
// - power-save keeps the asynchronous timer counting, everything else as power-down
// - adc noise mode halts core and peripherals except asynchronous timer and adc
// - standby keeps the main oscillator running so wake needs no start-up wait
// - extended standby keeps main oscillator and asynchronous timer running
// - any active reset floats every port pin at once, even without a clock
`timescale 1ns/100ps
`include "slpg_cfg.svh"
module slpg_top import slpg_pkg::*; #(
  parameter int NW = 8,
  parameter int NP = 48,
  parameter int OSC_START_CYC = `SLPG_OSC_START_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_req_i,
  input wire logic [2:0] mode_i,
  input wire logic [NW-1:0] wake_i,
  input wire logic [NW-1:0] wake_en_i,
  input wire logic [NP-1:0] port_out_i,
  input wire logic [NP-1:0] port_oe_i,
  output logic [NP-1:0] port_out_o,
  output logic [NP-1:0] port_oe_o,
  output logic cpu_clk_en_o,
  output logic io_clk_en_o,
  output logic adc_clk_en_o,
  output logic atmr_clk_en_o,
  output logic osc_en_o,
  output logic sleeping_o,
  output logic wake_o
);

  if (NW < 1 || NP < 1 || OSC_START_CYC < 1 || OSC_START_CYC > 65535) begin : g_param_chk
    $error("slpg_top: unsupported parameter values");
  end

  typedef struct packed {
    slpg_state_t state;
    slpg_mode_t mode;
    slpg_dom_t dom;
    logic [15:0] cnt;
    logic [NW-1:0] wk_s1;
    logic [NW-1:0] wk_s2;
    logic wake;
  } slpg_st_t;

  localparam logic [15:0] WARM_LAST = 16'(OSC_START_CYC - 1);

  slpg_st_t st_r;
  slpg_st_t st_nxt;
  logic rst_s1_r;
  logic rst_s2_r;
  logic legal_mode;
  logic wake_hit;

  // reset release synchroniser
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // domains kept running per mode
  function automatic slpg_dom_t dom_of(slpg_mode_t m);
    slpg_dom_t d;
    d = '0;
    unique case (m)
      SLPG_IDLE: d = `SLPG_DOM_RUN & ~(5'h1 << `SLPG_DOM_CPU);
      SLPG_ADC_NR: d = (5'h1 << `SLPG_DOM_ADC) | (5'h1 << `SLPG_DOM_ATMR) | (5'h1 << `SLPG_DOM_OSC);
      SLPG_PWR_DOWN: d = 5'h0;
      SLPG_PWR_SAVE: d = 5'h1 << `SLPG_DOM_ATMR;
      SLPG_STANDBY: d = 5'h1 << `SLPG_DOM_OSC;
      SLPG_EXT_STANDBY: d = (5'h1 << `SLPG_DOM_OSC) | (5'h1 << `SLPG_DOM_ATMR);
    endcase
    return d;
  endfunction : dom_of

  always_comb begin
    legal_mode = (mode_i == `SLPG_MODE_IDLE) || (mode_i == `SLPG_MODE_ADC_NR) ||
                 (mode_i == `SLPG_MODE_PWR_DOWN) || (mode_i == `SLPG_MODE_PWR_SAVE) ||
                 (mode_i == `SLPG_MODE_STANDBY) || (mode_i == `SLPG_MODE_EXT_STANDBY);
    wake_hit = |(st_r.wk_s2 & wake_en_i);
  end

  always_comb begin
    st_nxt = st_r;
    // two-stage wake synchroniser lives in the state struct
    st_nxt.wk_s1 = wake_i;
    st_nxt.wk_s2 = st_r.wk_s1;
    st_nxt.wake = 1'b0;
    unique case (st_r.state)
      SLPG_ST_RUN: begin
        if (sleep_req_i && legal_mode) begin
          st_nxt.state = SLPG_ST_SLEEP;
          st_nxt.mode = slpg_mode_t'(mode_i);
          st_nxt.dom = dom_of(slpg_mode_t'(mode_i));
        end
      end
      SLPG_ST_SLEEP: begin
        if (wake_hit) begin
          if (st_r.dom[`SLPG_DOM_OSC]) begin
            st_nxt.state = SLPG_ST_RUN;
            st_nxt.dom = `SLPG_DOM_RUN;
            st_nxt.wake = 1'b1;
          end else begin
            st_nxt.state = SLPG_ST_WARM;
            st_nxt.dom = st_r.dom | (5'h1 << `SLPG_DOM_OSC);
            st_nxt.cnt = '0;
          end
        end
      end
      SLPG_ST_WARM: begin
        if (st_r.cnt == WARM_LAST) begin
          st_nxt.state = SLPG_ST_RUN;
          st_nxt.dom = `SLPG_DOM_RUN;
          st_nxt.wake = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 16'h1;
        end
      end
      default: begin
        st_nxt.state = SLPG_ST_RUN;
        st_nxt.dom = `SLPG_DOM_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st_r <= '{state: SLPG_ST_RUN, mode: SLPG_IDLE, dom: `SLPG_DOM_RUN, cnt: 16'h0,
                wk_s1: '0, wk_s2: '0, wake: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_clk_en_o = st_r.dom[`SLPG_DOM_CPU];
  assign io_clk_en_o = st_r.dom[`SLPG_DOM_IO];
  assign adc_clk_en_o = st_r.dom[`SLPG_DOM_ADC];
  assign atmr_clk_en_o = st_r.dom[`SLPG_DOM_ATMR];
  assign osc_en_o = st_r.dom[`SLPG_DOM_OSC];
  assign sleeping_o = (st_r.state != SLPG_ST_RUN);
  assign wake_o = st_r.wake;

  slpg_port_if #(.NP(NP)) port_bus ();

  assign port_bus.out = port_out_i;
  assign port_bus.oe = port_oe_i;
  assign port_bus.rst_raw_n = rst_n_i;
  assign port_bus.rst_sync_n = rst_s2_r;
  assign port_out_o = port_bus.pin_out;
  assign port_oe_o = port_bus.pin_oe;

  // pins float on raw reset, without waiting for a clock
  slpg_port_gate u_gate (
    .port(port_bus.gate)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_s2_r);

  pins_float_a: assert property (disable iff (1'b0) !rst_n_i |-> port_oe_o == '0)
    else $error("port pins driven during reset");
  mode_take_a: assert property (!sleeping_o && sleep_req_i && legal_mode |=> sleeping_o && !cpu_clk_en_o)
    else $error("legal sleep request not taken");
  idle_dom_a: assert property (!sleeping_o && sleep_req_i && mode_i == `SLPG_MODE_IDLE
    |=> io_clk_en_o && adc_clk_en_o && atmr_clk_en_o && osc_en_o)
    else $error("idle stopped a running domain");
  down_dom_a: assert property (!sleeping_o && sleep_req_i && mode_i == `SLPG_MODE_PWR_DOWN
    |=> !(io_clk_en_o | adc_clk_en_o | atmr_clk_en_o | osc_en_o))
    else $error("power-down left a domain running");
  save_dom_a: assert property (!sleeping_o && sleep_req_i && mode_i == `SLPG_MODE_PWR_SAVE
    |=> atmr_clk_en_o && !osc_en_o && !io_clk_en_o)
    else $error("power-save domain set wrong");
  adc_dom_a: assert property (!sleeping_o && sleep_req_i && mode_i == `SLPG_MODE_ADC_NR
    |=> adc_clk_en_o && atmr_clk_en_o && !io_clk_en_o)
    else $error("adc noise mode domain set wrong");
  standby_fast_a: assert property (st_r.state == SLPG_ST_SLEEP && osc_en_o && wake_hit
    |=> wake_o && cpu_clk_en_o)
    else $error("standby wake not immediate");
  ext_dom_a: assert property (!sleeping_o && sleep_req_i && mode_i == `SLPG_MODE_EXT_STANDBY
    |=> osc_en_o && atmr_clk_en_o && !io_clk_en_o)
    else $error("extended standby domain set wrong");
  warm_wake_a: assert property (st_r.state == SLPG_ST_SLEEP && !osc_en_o && wake_hit
    |=> osc_en_o && !cpu_clk_en_o && sleeping_o && !wake_o)
    else $error("cold wake skipped oscillator start");
  wake_restore_a: assert property ($rose(wake_o) |-> cpu_clk_en_o && !sleeping_o
    && st_r.dom == `SLPG_DOM_RUN)
    else $error("wake did not restore clocks");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");
  sleep_hold_a: assert property (st_r.state == SLPG_ST_SLEEP && !wake_hit
    |=> st_r.state == SLPG_ST_SLEEP && $stable(st_r.dom) && $stable(st_r.mode))
    else $error("sleep state changed without wake");
  mode_refuse_a: assert property (!sleeping_o && sleep_req_i && !legal_mode |=> !sleeping_o)
    else $error("illegal sleep mode taken");
  pins_follow_a: assert property (rst_n_i |-> port_out_o == port_out_i && port_oe_o == port_oe_i)
    else $error("port pins not released after reset");
  warm_hold_a: assert property (st_r.state == SLPG_ST_WARM |-> osc_en_o && !cpu_clk_en_o && sleeping_o)
    else $error("warm-up released the core early");
  run_full_a: assert property (!sleeping_o |-> st_r.dom == `SLPG_DOM_RUN)
    else $error("running with a gated domain");
  osc_stop_a: assert property (st_r.state == SLPG_ST_SLEEP && st_r.mode == SLPG_PWR_DOWN
    |-> !osc_en_o && !atmr_clk_en_o)
    else $error("power-down kept a clock running");
  save_timer_a: assert property (st_r.state == SLPG_ST_SLEEP && st_r.mode == SLPG_PWR_SAVE
    |-> atmr_clk_en_o && !cpu_clk_en_o)
    else $error("power-save stopped the async timer");

  // main scenarios
  sleep_idle_c: cover property (sleeping_o && st_r.mode == SLPG_IDLE ##1 wake_o);
  sleep_down_c: cover property (st_r.state == SLPG_ST_WARM ##[1:40] wake_o);
  sleep_stby_c: cover property (st_r.mode == SLPG_STANDBY && wake_o);
  sleep_adc_c: cover property (st_r.mode == SLPG_ADC_NR && wake_o);
  sleep_refuse_c: cover property (!sleeping_o && sleep_req_i && !legal_mode);

endmodule : slpg_top

// *** hw/slpg_cfg.svh ***
`ifndef SLPG_CFG_SVH
`define SLPG_CFG_SVH

// sleep mode codes on mode_i
`define SLPG_MODE_IDLE 3'h0
`define SLPG_MODE_ADC_NR 3'h1
`define SLPG_MODE_PWR_DOWN 3'h2
`define SLPG_MODE_PWR_SAVE 3'h3
`define SLPG_MODE_STANDBY 3'h6
`define SLPG_MODE_EXT_STANDBY 3'h7

// domain enable bit positions: {osc, atmr, adc, io, cpu}
`define SLPG_DOM_CPU 0
`define SLPG_DOM_IO 1
`define SLPG_DOM_ADC 2
`define SLPG_DOM_ATMR 3
`define SLPG_DOM_OSC 4
`define SLPG_DOM_RUN 5'h1f

// oscillator start-up wait
`define SLPG_CLK_NS 40
`define SLPG_OSC_START_NS 1000
`define SLPG_OSC_START_CYC ((`SLPG_OSC_START_NS + `SLPG_CLK_NS - 1) / `SLPG_CLK_NS)

`endif

// *** hw/slpg_pkg.sv ***
package slpg_pkg;

  typedef enum logic [2:0] {
    SLPG_IDLE = 3'h0,
    SLPG_ADC_NR = 3'h1,
    SLPG_PWR_DOWN = 3'h2,
    SLPG_PWR_SAVE = 3'h3,
    SLPG_STANDBY = 3'h6,
    SLPG_EXT_STANDBY = 3'h7
  } slpg_mode_t;

  typedef enum logic [1:0] {
    SLPG_ST_RUN,
    SLPG_ST_SLEEP,
    SLPG_ST_WARM
  } slpg_state_t;

  typedef logic [4:0] slpg_dom_t;

endpackage : slpg_pkg

// *** hw/slpg_port_if.sv ***
`timescale 1ns/100ps
interface slpg_port_if #(
  parameter int NP = 48
);
  logic [NP-1:0] out;
  logic [NP-1:0] oe;
  logic rst_raw_n;
  logic rst_sync_n;
  logic [NP-1:0] pin_out;
  logic [NP-1:0] pin_oe;

  modport ctl (output out, output oe, output rst_raw_n, output rst_sync_n, input pin_out, input pin_oe);
  modport gate (input out, input oe, input rst_raw_n, input rst_sync_n, output pin_out, output pin_oe);
endinterface : slpg_port_if

// *** hw/slpg_port_gate.sv ***
`timescale 1ns/100ps
module slpg_port_gate (
  slpg_port_if.gate port
);
  logic rel;

  // pure gating, no clock needed to float the pins; release waits for rst_sync_n
  assign rel = port.rst_raw_n & port.rst_sync_n;
  assign port.pin_oe = port.oe & {$bits(port.oe){rel}};
  assign port.pin_out = port.out & {$bits(port.out){rel}};
endmodule : slpg_port_gate

// *** verif/slpg_tb_top.sv ***
`timescale 1ns/100ps
`include "slpg_cfg.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module sleep_mode_power_gating_tb_top import slpg_pkg::*;;
  localparam int NW = 8;
  localparam int NP = 48;
  localparam int OSC = 2;
  logic ref_clk_i, rst_n_i, sleep_req_i;
  logic [2:0] mode_i;
  logic [NW-1:0] wake_i, wake_en_i;
  logic [NP-1:0] port_out_i, port_oe_i, port_out_o, port_oe_o;
  logic cpu_clk_en_o, io_clk_en_o, adc_clk_en_o, atmr_clk_en_o, osc_en_o, sleeping_o, wake_o;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  slpg_dom_t dom;
  assign dom = {osc_en_o, atmr_clk_en_o, adc_clk_en_o, io_clk_en_o, cpu_clk_en_o};

  slpg_top #(.NW(NW), .NP(NP), .OSC_START_CYC(OSC)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sleep_req_i(sleep_req_i), .mode_i(mode_i),
    .wake_i(wake_i), .wake_en_i(wake_en_i), .port_out_i(port_out_i), .port_oe_i(port_oe_i),
    .port_out_o(port_out_o), .port_oe_o(port_oe_o), .cpu_clk_en_o(cpu_clk_en_o),
    .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o), .atmr_clk_en_o(atmr_clk_en_o),
    .osc_en_o(osc_en_o), .sleeping_o(sleeping_o), .wake_o(wake_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task report_and_stop;
    $display("TB: checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // hung handshake guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("ERROR t=%0t timeout", $time);
      report_and_stop();
    end
  end

  task do_reset;
    @(posedge ref_clk_i) rst_n_i <= 1'b0;
    #1;
    `CHK(port_oe_o, {NP{1'b0}})
    `CHK(port_out_o, {NP{1'b0}})
    repeat (6) @(posedge ref_clk_i);
    `CHK(dom, 5'h1f)
    `CHK(sleeping_o, 1'b0)
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(port_out_o, port_out_i)
    `CHK(port_oe_o, port_oe_i)
  endtask : do_reset

  task go_sleep(input logic [2:0] m, input slpg_dom_t exp);
    @(posedge ref_clk_i) sleep_req_i <= 1'b1;
    mode_i <= m;
    @(posedge ref_clk_i) sleep_req_i <= 1'b0;
    #1;
    `CHK(dom, exp)
    `CHK(sleeping_o, (exp != 5'h1f))
  endtask : go_sleep

  task sleep_wake(input logic [2:0] m, input slpg_dom_t exp, input int lat);
    int n;
    n = 0;
    go_sleep(m, exp);
    // second request while asleep is ignored
    go_sleep(SLPG_IDLE, exp);
    @(posedge ref_clk_i) wake_i <= 8'h02;
    repeat (5) @(posedge ref_clk_i);
    #1;
    `CHK(dom, exp)
    @(posedge ref_clk_i) wake_i <= 8'h03;
    while (n < 40) begin
      @(posedge ref_clk_i);
      n++;
      #1;
      if (wake_o === 1'b1) break;
    end
    `CHK(n, lat)
    `CHK(dom, 5'h1f)
    `CHK(sleeping_o, 1'b0)
    @(posedge ref_clk_i) wake_i <= 8'h00;
    #1;
    `CHK(wake_o, 1'b0)
    `CHK(dom, 5'h1f)
    repeat (4) @(posedge ref_clk_i);
  endtask : sleep_wake

  task illegal_modes;
    go_sleep(3'h4, 5'h1f);
    go_sleep(3'h5, 5'h1f);
  endtask : illegal_modes

  task reset_in_sleep;
    go_sleep(SLPG_PWR_DOWN, 5'h00);
    repeat (3) @(posedge ref_clk_i);
    do_reset();
  endtask : reset_in_sleep

  initial begin
    rst_n_i = 1'b0;
    sleep_req_i = 1'b0;
    mode_i = 3'h0;
    wake_i = 8'h00;
    wake_en_i = 8'h01;
    port_out_i = 48'ha5a5_5a5a_c3c3;
    port_oe_i = 48'hffff_0000_f0f0;
    do_reset();
    sleep_wake(SLPG_IDLE, 5'h1e, 3);
    sleep_wake(SLPG_ADC_NR, 5'h1c, 3);
    sleep_wake(SLPG_PWR_DOWN, 5'h00, 3 + OSC);
    sleep_wake(SLPG_PWR_SAVE, 5'h08, 3 + OSC);
    sleep_wake(SLPG_STANDBY, 5'h10, 3);
    sleep_wake(SLPG_EXT_STANDBY, 5'h18, 3);
    illegal_modes();
    reset_in_sleep();
    sleep_wake(SLPG_IDLE, 5'h1e, 3);
    report_and_stop();
  end
endmodule : sleep_mode_power_gating_tb_top
